// ==== core/smo_top.sv ====
// Supply-modulated calibration access, measuring outputs and motor step schedule
// Operation
// - Data shifted in LSB first, MSB last
// - Prestore then store copies register to word
// - Readback word by state, bit by pointer
// - Set cell enables supply load
// - Measuring states drive pad and load
// - State 1 outputs crystal divided by 1024
// - State 2 period base plus n steps
// - Pad low selects test mode, 8 Hz
// - Test mode checks every second
// - Test mode depleted steps 32 Hz, max
// - Battery sampled every four minutes
// - Depleted: four-pulse burst every 4 s
// - Depleted: no detection, highest level
// - Gap length selects count, zero, one
// - Start pulse gives state 1, clears register
// - States end on timeout, stop, store
// - States 3-5 words A-C, 6 check only
module smo_top
  import smo_pkg::*;
#(
  parameter int SEC_TICKS = SEC_TICKS_DEF,
  parameter int TIMEOUT_TICKS = TIMEOUT_TICKS_DEF,
  parameter int BATT_TICKS = BATT_TICKS_DEF,
  parameter int BURST_TICKS = BURST_TICKS_DEF,
  parameter int TICK_DIV = XTAL_DIV
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supply level detectors
  input wire logic mod_det,
  input wire logic hv_det,
  input wire logic store_det,
  input wire logic batt_low,
  // Reset pad, three signals
  input wire logic reset_pad_in,
  output logic reset_pad_out,
  output logic reset_pad_oe_b,
  // Supply current load
  output logic load_en,
  // Motor schedule
  output logic motor_step,
  output logic motor_pol,
  output logic drive_max,
  output logic step_detect_en,
  output logic duty_adapt_tick,
  output logic battery_depleted
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic [2:0] pin_d;
  logic mod_rise, hv_rise, store_rise;
  logic [XDIV_W-1:0] xdiv;
  logic tick;
  smo_state_e state;
  logic [7:0] sr;
  logic armed, data_last;
  logic [7:0] otp [0:2];
  logic [CNT_W-1:0] idle_cnt;
  logic timeout, wr_fire, stop_fire, meas, writable;
  logic [1:0] widx;
  logic [7:0] word_val;
  logic rd_bit;
  logic [CNT_W-1:0] meas_cnt, meas_period;
  logic meas_hi;
  logic test_mode;
  logic [1:0] oe_dly;
  logic [CNT_W-1:0] mot_cnt, mot_period, batt_cnt, batt_period;
  logic [1:0] burst_idx;
  logic mot_wrap, batt_wrap;

  smo_gap_if gif ();

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Pins: mod, hv, store, battery, pad
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_m <= 5'h10;
      pin_s <= 5'h10;
      pin_d <= 3'h0;
    end
    else
    begin
      pin_m <= {reset_pad_in, batt_low, store_det, hv_det, mod_det};
      pin_s <= pin_m;
      pin_d <= pin_s[2:0];
    end
  end
  assign mod_rise = pin_s[0] && !pin_d[0];
  assign hv_rise = pin_s[1] && !pin_d[1];
  assign store_rise = pin_s[2] && !pin_d[2];

  // Crystal-rate tick enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      xdiv <= '0;
    else if (xdiv == XDIV_W'(TICK_DIV - 1))
      xdiv <= '0;
    else
      xdiv <= xdiv + XDIV_W'(1);
  end
  assign tick = (xdiv == XDIV_W'(TICK_DIV - 1));

  assign meas = (state == ST_MEAS_OSC) || (state == ST_MEAS_INHIB);
  // only words A to C take a store
  assign writable = (state == ST_WORD_A) || (state == ST_WORD_B) || (state == ST_WORD_C);
  assign widx = 2'(state - ST_WORD_A);
  // idle time since last supply pulse
  assign timeout = (state != ST_IDLE) && tick && (idle_cnt >= CNT_W'(TIMEOUT_TICKS - 1));
  // store level while armed writes the word
  assign wr_fire = store_rise && armed && writable;
  // A high pulse not following data closely is a stop
  assign stop_fire = hv_rise && (state != ST_IDLE) &&
                     !(data_last && writable && gif.gap <= GAP_W'(T4_HI));

  assign gif.tick = tick;
  assign gif.mod_evt = mod_rise && (state != ST_IDLE);
  assign gif.restart = hv_rise || store_rise || timeout;

  smo_gap_decoder u_dec (
    .clk (clk),
    .rst_n (rst_n),
    .gif (gif)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_cnt <= '0;
    else if (mod_rise || hv_rise || store_rise || state == ST_IDLE)
      idle_cnt <= '0;
    else if (tick)
      idle_cnt <= idle_cnt + CNT_W'(1);
  end

  // Instruction counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else if (timeout || store_rise || stop_fire)
      state <= ST_IDLE;
    else if (hv_rise && state == ST_IDLE)
      state <= ST_MEAS_OSC;
    else if (gif.inc)
    begin
      case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_WORD_D: state <= ST_WORD_D;
        default: state <= smo_state_e'(state + 3'h1);
      endcase
    end
  end

  // Shift register and prestore arming
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr <= SR_CLEAR;
      armed <= 1'b0;
      data_last <= 1'b0;
    end
    else if (hv_rise && state == ST_IDLE)
    begin
      sr <= SR_CLEAR;
      armed <= 1'b0;
      data_last <= 1'b0;
    end
    else if (timeout || store_rise || stop_fire)
    begin
      armed <= 1'b0;
      data_last <= 1'b0;
    end
    // prestore shortly after the last data bit
    else if (hv_rise)
      armed <= 1'b1;
    // new bit enters at bit 8 and moves toward bit 1
    else if (gif.shift)
    begin
      sr <= {gif.shift_bit, sr[7:1]};
      data_last <= 1'b1;
    end
    else if (gif.inc)
      data_last <= 1'b0;
  end

  // Fuses only ever go from blank to set, so a store ORs in
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      otp[0] <= OTP_BLANK;
      otp[1] <= OTP_BLANK;
      otp[2] <= OTP_BLANK;
    end
    else if (wr_fire)
      otp[widx] <= otp[widx] | sr;
  end

  // word from state, bit from pointer position
  always_comb
  begin
    case (state)
      ST_WORD_A: word_val = otp[0];
      ST_WORD_B: word_val = otp[1];
      ST_WORD_C: word_val = otp[2];
      ST_WORD_D: word_val = WORD_D_VAL;
      default: word_val = OTP_BLANK;
    endcase
  end
  assign rd_bit = ($countones(sr) == 1) && ((word_val & sr) != 8'h00);

  assign meas_period = (state == ST_MEAS_OSC) ? CNT_W'(OSC_DIVIDE) :
                       CNT_W'(MEAS2_BASE) + CNT_W'(INHIB_STEP) * CNT_W'(otp[0][7:1]);
  assign meas_hi = meas && (meas_cnt < CNT_W'(MEAS1_HALF));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      meas_cnt <= '0;
    else if (!meas)
      meas_cnt <= '0;
    else if (tick)
      meas_cnt <= (meas_cnt >= meas_period - CNT_W'(1)) ? '0 : meas_cnt + CNT_W'(1);
  end

  // load follows cell or measuring signal
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_pad_out <= 1'b0;
      reset_pad_oe_b <= 1'b1;
      load_en <= 1'b0;
    end
    else
    begin
      reset_pad_out <= meas_hi;
      reset_pad_oe_b <= !meas;
      load_en <= meas ? meas_hi : rd_bit;
    end
  end

  // Pad copy lags our own release by two cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_dly <= 2'h3;
    else
      oe_dly <= {oe_dly[0], reset_pad_oe_b};
  end

  // pad held low means test; ignored while we drive it
  assign test_mode = !pin_s[4] && reset_pad_oe_b && (oe_dly == 2'h3);

  assign batt_period = test_mode ? CNT_W'(SEC_TICKS) : CNT_W'(BATT_TICKS);
  assign batt_wrap = tick && (batt_cnt >= batt_period - CNT_W'(1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      batt_cnt <= '0;
      battery_depleted <= 1'b0;
      duty_adapt_tick <= 1'b0;
    end
    else
    begin
      duty_adapt_tick <= batt_wrap;
      if (batt_wrap)
      begin
        batt_cnt <= '0;
        battery_depleted <= pin_s[3];
      end
      else if (tick)
        batt_cnt <= batt_cnt + CNT_W'(1);
    end
  end

  always_comb
  begin
    if (test_mode)
      mot_period = battery_depleted ? CNT_W'(TEST_DEPL_PERIOD) : CNT_W'(TEST_PERIOD);
    else if (!battery_depleted)
      mot_period = CNT_W'(SEC_TICKS);
    else if (burst_idx != 2'(BURST_PULSES - 1))
      mot_period = CNT_W'(BURST_GAP_TICKS);
    else
      mot_period = CNT_W'(BURST_TICKS) - CNT_W'((BURST_PULSES - 1) * BURST_GAP_TICKS);
  end
  assign mot_wrap = tick && (mot_cnt >= mot_period - CNT_W'(1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mot_cnt <= '0;
      burst_idx <= 2'h0;
      motor_step <= 1'b0;
      motor_pol <= 1'b0;
    end
    else
    begin
      motor_step <= mot_wrap;
      if (mot_wrap)
      begin
        mot_cnt <= '0;
        motor_pol <= !motor_pol;
        burst_idx <= (battery_depleted && !test_mode) ? burst_idx + 2'h1 : 2'h0;
      end
      else if (tick)
        mot_cnt <= mot_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_max <= 1'b0;
      step_detect_en <= 1'b1;
    end
    else
    begin
      drive_max <= battery_depleted;
      step_detect_en <= !battery_depleted;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_store_write;
    wr_fire ##1 (state == ST_IDLE);
  endsequence

  a_start_clears: assert property ((hv_rise && state == ST_IDLE) |=> (state == ST_MEAS_OSC && sr == SR_CLEAR))
    else $error("start pulse did not enter state 1 with cleared register");
  a_shift_order: assert property (gif.shift && !hv_rise |=> sr[7] == $past(gif.shift_bit) && sr[6:0] == $past(sr[7:1]))
    else $error("shift register order wrong");
  a_store_copy: assert property (s_store_write |-> (otp[$past(widx)] & $past(sr)) == $past(sr))
    else $error("store did not copy register to word");
  a_read_load: assert property ((!meas && rd_bit && !timeout && !gif.shift) |=> load_en ##1 (load_en || !rd_bit || meas))
    else $error("load not enabled for set cell");
  a_meas_load: assert property (!reset_pad_oe_b && reset_pad_out |-> load_en)
    else $error("measuring high without load");
  a_osc_half: assert property ((state == ST_MEAS_OSC) && tick && meas_cnt == CNT_W'(MEAS1_HALF - 1) ##1 (state == ST_MEAS_OSC) |=> !reset_pad_out)
    else $error("state 1 output not divided by 1024");
  a_inhib_period: assert property (meas && state == ST_MEAS_INHIB |-> meas_period == CNT_W'(MEAS2_BASE + INHIB_STEP * otp[0][7:1]))
    else $error("inhibition period wrong");
  a_timeout_end: assert property (timeout && !hv_rise |=> state == ST_IDLE)
    else $error("instruction state survived timeout");
  a_word_d_hold: assert property ((state == ST_WORD_D) && gif.inc && !gif.restart |=> state == ST_WORD_D)
    else $error("counter moved past word D");
  a_batt_sample: assert property (batt_wrap |=> battery_depleted == $past(pin_s[3]) ##1 duty_adapt_tick == 1'b0)
    else $error("battery sample not taken");
  a_depl_drive: assert property (battery_depleted ##1 battery_depleted |-> drive_max && !step_detect_en)
    else $error("depleted battery not at highest drive");
endmodule // smo_top

// ==== core/smo_pkg.sv ====
// Constants and types of the supply-modulated calibration and motor schedule block
package smo_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int XTAL_HZ = 32768;
  // Crystal tick enable from the system clock, nearest whole divide
  localparam int XTAL_DIV = (CLK_HZ + XTAL_HZ / 2) / XTAL_HZ;
  localparam int XDIV_W = 12;

  // Gap windows in microseconds
  localparam int T1_MIN_US = 600;
  localparam int T1_MAX_US = 800;
  localparam int T2_MIN_US = 1600;
  localparam int T2_MAX_US = 1800;
  localparam int T3_MIN_US = 2600;
  localparam int T3_MAX_US = 2800;
  localparam int T4_MAX_US = 300;
  localparam int TIMEOUT_S = 2;
  localparam int MEAS2_BASE_US = 31250;
  localparam int INHIB_PULSE_HZ = 8192;
  localparam int OSC_DIVIDE = 1024;
  localparam int TEST_STEP_HZ = 8;
  localparam int TEST_DEPL_STEP_HZ = 32;
  localparam int BATT_NORMAL_MIN = 4;
  localparam int BURST_PERIOD_S = 4;
  localparam int BURST_PULSES = 4;
  localparam int BURST_GAP_TICKS = 1024;

  localparam int GAP_W = 8;
  localparam int CNT_W = 24;

  function automatic int us_ceil_ticks(input int us);
    return (us * XTAL_HZ + 999_999) / 1_000_000;
  endfunction

  function automatic int us_floor_ticks(input int us);
    return (us * XTAL_HZ) / 1_000_000;
  endfunction

  localparam int T1_LO = us_ceil_ticks(T1_MIN_US);
  localparam int T1_HI = us_floor_ticks(T1_MAX_US);
  localparam int T2_LO = us_ceil_ticks(T2_MIN_US);
  localparam int T2_HI = us_floor_ticks(T2_MAX_US);
  localparam int T3_LO = us_ceil_ticks(T3_MIN_US);
  localparam int T3_HI = us_floor_ticks(T3_MAX_US);
  localparam int T4_HI = us_floor_ticks(T4_MAX_US);
  localparam int MEAS1_HALF = OSC_DIVIDE / 2;
  localparam int MEAS2_BASE = us_floor_ticks(MEAS2_BASE_US);
  localparam int INHIB_STEP = XTAL_HZ / INHIB_PULSE_HZ;
  localparam int TEST_PERIOD = XTAL_HZ / TEST_STEP_HZ;
  localparam int TEST_DEPL_PERIOD = XTAL_HZ / TEST_DEPL_STEP_HZ;
  localparam int SEC_TICKS_DEF = XTAL_HZ;
  localparam int TIMEOUT_TICKS_DEF = TIMEOUT_S * XTAL_HZ;
  localparam int BATT_TICKS_DEF = BATT_NORMAL_MIN * 60 * XTAL_HZ;
  localparam int BURST_TICKS_DEF = BURST_PERIOD_S * XTAL_HZ;

  localparam logic [7:0] OTP_BLANK = 8'h00;
  localparam logic [7:0] SR_CLEAR = 8'h00;
  // Type-recognition word, value arbitrary
  localparam logic [7:0] WORD_D_VAL = 8'h5a;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEAS_OSC = 3'b001,
    ST_MEAS_INHIB = 3'b010,
    ST_WORD_A = 3'b011,
    ST_WORD_B = 3'b100,
    ST_WORD_C = 3'b101,
    ST_WORD_D = 3'b110
  } smo_state_e;
endpackage

// ==== core/smo_gap_if.sv ====
// Carrier between the gap decoder and the control logic
interface smo_gap_if;
  import smo_pkg::*;
  logic tick;
  logic mod_evt;
  logic restart;
  logic inc;
  logic shift;
  logic shift_bit;
  logic [GAP_W-1:0] gap;
  modport dec (input tick, mod_evt, restart, output inc, shift, shift_bit, gap);
  modport ctl (output tick, mod_evt, restart, input inc, shift, shift_bit, gap);
endinterface

// ==== core/smo_gap_decoder.sv ====
// Times gaps between modulation pulses in crystal ticks and classifies them
module smo_gap_decoder
  import smo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  smo_gap_if.dec gif
);
  logic has_ref;

  function automatic logic in_win(input logic [GAP_W-1:0] g, input int lo, input int hi);
    return (g >= GAP_W'(lo)) && (g <= GAP_W'(hi));
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gif.gap <= '0;
    else if (gif.mod_evt || gif.restart)
      gif.gap <= '0;
    else if (gif.tick && gif.gap != '1)
      gif.gap <= gif.gap + GAP_W'(1);
  end

  // First pulse after a restart only sets the time reference
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      has_ref <= 1'b0;
    else if (gif.restart)
      has_ref <= 1'b0;
    else if (gif.mod_evt)
      has_ref <= 1'b1;
  end

  // gap windows to count, zero or one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gif.inc <= 1'b0;
      gif.shift <= 1'b0;
      gif.shift_bit <= 1'b0;
    end
    else
    begin
      gif.inc <= gif.mod_evt && has_ref && !gif.restart && in_win(gif.gap, T1_LO, T1_HI);
      gif.shift <= gif.mod_evt && has_ref && !gif.restart &&
                   (in_win(gif.gap, T2_LO, T2_HI) || in_win(gif.gap, T3_LO, T3_HI));
      gif.shift_bit <= in_win(gif.gap, T3_LO, T3_HI);
    end
  end
endmodule // smo_gap_decoder

// ==== dv/smo_station.sv ====
// Programming station model that modulates the supply level detectors
module smo_station
  import smo_pkg::*;
#(
  parameter int T0_TICKS = 656
)
(
  // Clock and crystal-rate tick
  input wire logic clk,
  input wire logic tick,
  // Supply level detectors
  output logic mod_det,
  output logic hv_det,
  output logic store_det
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    mod_det = 1'b0;
    hv_det = 1'b0;
    store_det = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Gaps counted in crystal ticks, the device's own time base
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (!tick)
        @(posedge clk);
    end
    #1;
  endtask

  task automatic mod_at(input int n);
    ticks(n);
    mod_det = 1'b1;
    cyc(3);
    mod_det = 1'b0;
  endtask

  // Level pulse; low time after it keeps back-to-back pulses apart
  task automatic hv_pulse();
    hv_det = 1'b1;
    cyc(4);
    hv_det = 1'b0;
    cyc(4);
  endtask

  task automatic select(input int incs);
    hv_pulse();
    ticks(T0_TICKS);
    mod_at(1);
    repeat (incs) mod_at(23);
  endtask

  // bit 1 first, bit 8 last
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      mod_at(v[i] ? 88 : 56);
  endtask

  task automatic store();
    ticks(5);
    hv_pulse();
    ticks(2);
    store_det = 1'b1;
    cyc(4);
    store_det = 1'b0;
    cyc(4);
  endtask
endmodule // smo_station

// ==== dv/tb.sv ====
// Self-checking bench of the supply-modulated access and motor schedule
module tb
  import smo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SEC = 64;
  localparam int TMO = 800;
  localparam int BATT = 100;
  // Short crystal tick keeps the run small; gaps still counted in ticks
  localparam int TDIV = 8;
  localparam int LIMIT = 90_000;
  localparam logic [7:0] WORD_B = 8'h35;

  logic clk;
  logic rst_b;
  logic batt_low;
  logic pad_tie;
  logic mod_det;
  logic hv_det;
  logic store_det;
  logic reset_pad_in;
  logic reset_pad_out;
  logic reset_pad_oe_b;
  logic load_en;
  logic motor_step;
  logic motor_pol;
  logic drive_max;
  logic step_detect_en;
  logic duty_adapt_tick;
  logic battery_depleted;
  int num_errors;
  int n_compared;
  int cycles;
  int xcnt;
  logic xtick;

  // Pad level: device drive wins over the external tie
  assign reset_pad_in = reset_pad_oe_b ? pad_tie : reset_pad_out;

  smo_station i_station (
    .clk(clk),
    .tick(xtick),
    .mod_det(mod_det),
    .hv_det(hv_det),
    .store_det(store_det)
  );

  smo_top #(.SEC_TICKS(SEC), .TIMEOUT_TICKS(TMO), .BATT_TICKS(BATT), .TICK_DIV(TDIV)) i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .mod_det(mod_det),
    .hv_det(hv_det),
    .store_det(store_det),
    .batt_low(batt_low),
    .reset_pad_in(reset_pad_in),
    .reset_pad_out(reset_pad_out),
    .reset_pad_oe_b(reset_pad_oe_b),
    .load_en(load_en),
    .motor_step(motor_step),
    .motor_pol(motor_pol),
    .drive_max(drive_max),
    .step_detect_en(step_detect_en),
    .duty_adapt_tick(duty_adapt_tick),
    .battery_depleted(battery_depleted)
  );

  always #5 clk = ~clk;

  // Station pacing, independent of the design's divider
  always @(posedge clk)
  begin
    xcnt <= (xcnt == TDIV - 1) ? 0 : xcnt + 1;
    xtick <= (xcnt == TDIV - 1);
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int sel);
    return sel ? duty_adapt_tick : motor_step;
  endfunction

  // Cycles from one pulse of the chosen output to the next
  task automatic gap_of(input int sel, output int n);
    int k;
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (pick(sel) !== 1'b1 && k < 800000);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (pick(sel) !== 1'b1 && n < 800000);
  endtask

  task automatic t_reset();
    check("pad_oe_b", 1, reset_pad_oe_b);
    check("detect_en", 1, step_detect_en);
    check("load_en", 0, load_en);
  endtask

  task automatic t_normal();
    int n;
    gap_of(0, n);
    check("step_gap", SEC * TDIV, n);
    gap_of(1, n);
    check("batt_gap", BATT * TDIV, n);
  endtask

  // Battery goes low just after a sample, seen only at the next one
  task automatic t_depleted();
    int n;
    batt_low = 1'b1;
    cyc(50 * TDIV);
    check("depl_early", 0, battery_depleted);
    gap_of(1, n);
    check("depl", 1, battery_depleted);
    check("detect_off", 0, step_detect_en);
    check("drive_max", 1, drive_max);
  endtask

  task automatic t_test_mode();
    int n;
    pad_tie = 1'b0;
    gap_of(1, n);
    gap_of(1, n);
    check("test_batt_gap", SEC * TDIV, n);
    check("test_drive_max", 1, drive_max);
    gap_of(0, n);
    check("test_depl_step", TEST_DEPL_PERIOD * TDIV, n);
    pad_tie = 1'b1;
    batt_low = 1'b0;
  endtask

  task automatic t_write_b();
    i_station.select(3);
    i_station.send_byte(WORD_B);
    i_station.store();
  endtask

  // Walk a single one from bit 8 down to bit 1
  task automatic t_read_b();
    i_station.select(3);
    i_station.mod_at(88);
    cyc(10);
    check("read_bit7", WORD_B[7], load_en);
    for (int i = 6; i >= 0; i--)
    begin
      i_station.mod_at(56);
      cyc(10);
      check("read_bit", WORD_B[i], load_en);
    end
    i_station.ticks(20);
    i_station.hv_pulse();
  endtask

  // Settle wait puts the output in its low half; next high half follows the 1024-tick wrap
  task automatic t_meas_timeout();
    i_station.select(0);
    cyc(10);
    check("meas_oe_b", 0, reset_pad_oe_b);
    check("meas_low", 0, reset_pad_out);
    check("meas_load_off", 0, load_en);
    i_station.ticks(440);
    check("meas_high", 1, reset_pad_out);
    check("meas_load", 1, load_en);
    i_station.ticks(340);
    check("meas_alive", 0, reset_pad_oe_b);
    i_station.ticks(40);
    check("timed_out", 1, reset_pad_oe_b);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    batt_low = 1'b0;
    pad_tie = 1'b1;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    xcnt = 0;
    xtick = 1'b0;
    cyc(2);
    t_reset();
    rst_b = 1'b1;
    cyc(3);
    t_normal();
    t_depleted();
    t_test_mode();
    t_write_b();
    t_read_b();
    t_meas_timeout();
    give_verdict();
  end
endmodule // tb
